// *** design/ecs_exec_cycle.sv ***
// Purpose: status word, transfer buffers, instruction fetch and cycle clocks
// Assumes: timebase and pins are asynchronous; microcode arrives on clk_in
// Notes:   all cycle clocks are flops, one clk_in behind the phase state
`timescale 1ns/10ps
`default_nettype none
module ecs_exec_cycle
  import ecs_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wr_data_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rd_data_out,
  input  wire logic        timebase_in,
  input  wire logic        bus_ready_n_in,
  input  wire logic        intr_unit_ready_n_in,
  input  wire logic        dma_pause_n_in,
  input  wire logic        hold_req_n_in,
  input  wire logic [19:0] microcode_in,
  input  wire logic [15:0] y_bus_in,
  input  wire logic        y_carry_in,
  input  wire logic [15:0] ad_in,
  output logic      [15:0] ad_out,
  output logic             ad_oe_out,
  output logic             cycle_sync_n_out,
  output logic             intr_unit_cycle_clock_n_out,
  output logic             internal_cycle_clock_n_out,
  output logic             precharge_clock_n_out,
  output logic             phase_two_clock_n_out,
  output logic             addr_strobe_out,
  output logic             data_strobe_n_out,
  output logic             read_write_n_out,
  output logic             instr_or_operand_out,
  output logic             memory_or_io_out,
  output logic             ctrl_oe_out,
  output logic             hold_ack_n_out,
  output logic             branch_taken_out,
  output logic      [15:0] r_bus_out,
  output logic      [15:0] s_bus_out,
  output logic      [15:0] prefetch_current_out,
  output logic      [15:0] prefetch_next_out,
  output logic      [15:0] input_buffer_out
);
  import ecs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: only the second stage is read by logic, except the timebase edge detect, which also reads the third stage tb3_r
  logic [4:0]  s1_r;
  logic [4:0]  s2_r;
  logic        tb3_r;
  logic [15:0] ad1_r;
  logic [15:0] ad2_r;
  always_ff @(posedge clk_in or negedge rstn_in)
    if (!rstn_in)
    begin
      s1_r  <= 5'h1F;
      s2_r  <= 5'h1F;
      tb3_r <= 1'b1;
      ad1_r <= 16'h0000;
      ad2_r <= 16'h0000;
    end
    else
    begin
      s1_r  <= {hold_req_n_in, dma_pause_n_in, intr_unit_ready_n_in,
                bus_ready_n_in, timebase_in};
      s2_r  <= s1_r;
      tb3_r <= s2_r[0];
      ad1_r <= ad_in;
      ad2_r <= ad1_r;
    end
  logic osc_fall;
  logic rdy_n;
  logic irdy_n;
  logic pause_n;
  logic hreq_n;
  assign osc_fall = tb3_r & ~s2_r[0];
  assign rdy_n    = s2_r[1];
  assign irdy_n   = s2_r[2];
  assign pause_n  = s2_r[3];
  assign hreq_n   = s2_r[4];

  ////////////////////////////////////////////////////////////////////////////
  // machine cycle sequencer
  ecs_phase_t ph_r;
  ecs_phase_t ph_nxt;
  logic       stall_r;
  logic       stall_nxt;
  logic       hack_r;
  logic       hack_nxt;
  logic       end_c;
  logic [19:0] ex_r;
  ecs_bop_t   bop;
  logic       long_c;
  assign bop    = ecs_bop_t'(ex_r[MW_BOP +: 2]);
  assign long_c = ex_r[MW_BRA] | (bop == BOP_IIO);

  always_comb
  begin
    ph_nxt    = ph_r;
    stall_nxt = stall_r;
    hack_nxt  = hack_r;
    end_c     = 1'b0;
    if (osc_fall)
    begin
      case (ph_r)
        PH0:
        begin
          if (!stall_r)
            ph_nxt = PH1;
          else if (pause_n && hreq_n)
          begin
            stall_nxt = 1'b0;
            hack_nxt  = 1'b0;
          end
        end
        PH1: ph_nxt = PH2;
        PH2: ph_nxt = PH3;
        PH3: ph_nxt = PH4;
        PH4:
        begin
          if ((bop == BOP_READ || bop == BOP_WRITE) && rdy_n)
            ph_nxt = PWAIT;
          else if (long_c)
            ph_nxt = PH5;
          else
            end_c = 1'b1;
        end
        PH5:
        begin
          if (bop == BOP_IIO && irdy_n)
            ph_nxt = PWAIT;
          else
            end_c = 1'b1;
        end
        PWAIT:
        begin
          if (bop == BOP_IIO ? !irdy_n : !rdy_n)
            end_c = 1'b1;
        end
        default: ph_nxt = PH0;
      endcase
      // new cycle starts in phase zero
      if (end_c)
      begin
        ph_nxt    = PH0;
        stall_nxt = !pause_n || !hreq_n;
        hack_nxt  = !hreq_n;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in)
    if (!rstn_in)
    begin
      ph_r    <= PH0;
      stall_r <= 1'b0;
      hack_r  <= 1'b0;
    end
    else
    begin
      ph_r    <= ph_nxt;
      stall_r <= stall_nxt;
      hack_r  <= hack_nxt;
    end

  ////////////////////////////////////////////////////////////////////////////
  // datapath: status word, counter, prefetch and transfer buffers
  logic [15:0] sw_r, sw_nxt, ic_r, ic_nxt, cur_r, cur_nxt, pnx_r, pnx_nxt;
  logic [15:0] ib_r, ib_nxt, ab_r, ab_nxt, ob_r, ob_nxt;
  logic [19:0] ex_nxt;
  logic        taken;
  assign taken = ~|ex_r[MW_CND +: 4] | |(ex_r[MW_CND +: 4] & sw_r[3:0]);

  always_comb
  begin
    sw_nxt  = sw_r;
    ic_nxt  = ic_r;
    cur_nxt = cur_r;
    pnx_nxt = pnx_r;
    ib_nxt  = ib_r;
    ab_nxt  = ab_r;
    ob_nxt  = ob_r;
    ex_nxt  = ex_r;
    if (wr_in && addr_in == ADR_STATUS)
      sw_nxt = wr_data_in[15:0] & SW_MASK;
    if (wr_in && addr_in == ADR_ICNT)
      ic_nxt = wr_data_in[15:0];
    if (end_c)
    begin
      ex_nxt = microcode_in;
      if (ex_r[MW_FLG])
      begin
        sw_nxt[F_CARRY] = y_carry_in;
        sw_nxt[F_POS]   = !y_bus_in[15] && (y_bus_in != 16'h0000);
        sw_nxt[F_ZERO]  = (y_bus_in == 16'h0000);
        sw_nxt[F_NEG]   = y_bus_in[15];
      end
      if (ex_r[MW_SWL])
      begin
        sw_nxt[PS_LO +: 4] = y_bus_in[PS_LO +: 4];
        sw_nxt[AS_LO +: 4] = y_bus_in[AS_LO +: 4];
      end
      if (ex_r[MW_ICL] && taken)
        ic_nxt = y_bus_in;
      else if (ex_r[MW_INC])
        ic_nxt = ic_r + 16'h0001;
      if (ex_r[MW_ADL])
        ab_nxt = y_bus_in;
      if (ex_r[MW_DOL])
        ob_nxt = y_bus_in;
      // next and input buffer load together on a read with advance, unless MW_IMM is set
      if (bop == BOP_READ && ex_r[MW_ADV])
      begin
        cur_nxt = pnx_r;
        pnx_nxt = ad2_r;
        if (!ex_r[MW_IMM])
          ib_nxt = ad2_r;
      end
      else if (bop == BOP_READ)
      begin
        if (ex_r[MW_IOP])
          pnx_nxt = ad2_r;
        else
          ib_nxt = ad2_r;
      end
      else if (ex_r[MW_ADV])
        cur_nxt = pnx_r;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in)
    if (!rstn_in)
    begin
      sw_r  <= SW_RST;
      ic_r  <= IC_RST;
      cur_r <= 16'h0000;
      pnx_r <= 16'h0000;
      ib_r  <= 16'h0000;
      ab_r  <= 16'h0000;
      ob_r  <= 16'h0000;
      ex_r  <= 20'h00000;
    end
    else
    begin
      sw_r  <= sw_nxt;
      ic_r  <= ic_nxt;
      cur_r <= cur_nxt;
      pnx_r <= pnx_nxt;
      ib_r  <= ib_nxt;
      ab_r  <= ab_nxt;
      ob_r  <= ob_nxt;
      ex_r  <= ex_nxt;
    end

  ////////////////////////////////////////////////////////////////////////////
  // pins and outputs, registered from the phase state
  logic        quiet;
  logic        busy;
  logic        adph;
  logic [15:0] ad_nxt;
  logic        adoe_nxt;
  logic [31:0] rd_nxt;
  assign quiet = !pause_n || hack_r;
  assign busy  = (bop != BOP_NONE);
  assign adph  = (ph_r == PH0) || (ph_r == PH1);

  always_comb
  begin
    ad_nxt   = adph ? ((bop == BOP_READ && ex_r[MW_IOP]) ? ic_r : ab_r) : ob_r;
    adoe_nxt = !quiet && busy && (adph || bop == BOP_WRITE);
    rd_nxt   = 32'h00000000;
    if (addr_in == ADR_STATUS)
      rd_nxt[15:0] = sw_r;
    else if (addr_in == ADR_ICNT)
      rd_nxt[15:0] = ic_r;
    else if (addr_in == ADR_PCUR)
      rd_nxt[15:0] = cur_r;
    else if (addr_in == ADR_PNXT)
      rd_nxt[15:0] = pnx_r;
    else if (addr_in == ADR_INBUF)
      rd_nxt[15:0] = ib_r;
    else if (addr_in == ADR_SEQ)
      rd_nxt[4:0] = {hack_r, stall_r, ph_r};
    if (!rd_in)
      rd_nxt = 32'h00000000;
  end

  always_ff @(posedge clk_in or negedge rstn_in)
    if (!rstn_in)
    begin
      cycle_sync_n_out            <= 1'b0;
      intr_unit_cycle_clock_n_out <= 1'b0;
      internal_cycle_clock_n_out  <= 1'b0;
      precharge_clock_n_out       <= 1'b0;
      phase_two_clock_n_out       <= 1'b1;
      addr_strobe_out             <= 1'b0;
      data_strobe_n_out           <= 1'b1;
      read_write_n_out            <= 1'b1;
      instr_or_operand_out        <= 1'b0;
      memory_or_io_out            <= 1'b1;
      ctrl_oe_out                 <= 1'b0;
      hold_ack_n_out              <= 1'b1;
      branch_taken_out            <= 1'b0;
      ad_out                      <= 16'h0000;
      ad_oe_out                   <= 1'b0;
      r_bus_out                   <= 16'h0000;
      s_bus_out                   <= 16'h0000;
      rd_data_out                 <= 32'h00000000;
    end
    else
    begin
      // five clocks from one phase state
      cycle_sync_n_out            <= !adph;
      intr_unit_cycle_clock_n_out <= !adph;
      // internal and precharge held low, phase two held high, during pause or hold
      internal_cycle_clock_n_out  <= !adph && !quiet;
      precharge_clock_n_out       <= (ph_r != PH0) && !quiet;
      phase_two_clock_n_out       <= quiet || adph || (ph_r == PH2);
      addr_strobe_out             <= busy && (ph_r == PH0);
      data_strobe_n_out           <= !(busy && !adph && ph_r != PH2) || !busy;
      read_write_n_out            <= (bop != BOP_WRITE);
      instr_or_operand_out        <= ex_r[MW_IOP];
      memory_or_io_out            <= !busy || ex_r[MW_MEM];
      ctrl_oe_out                 <= !quiet;
      hold_ack_n_out              <= !hack_r;
      branch_taken_out            <= taken;
      ad_out                      <= ad_nxt;
      ad_oe_out                   <= adoe_nxt;
      // counter, buffers and status word onto source buses
      r_bus_out                   <= ex_r[MW_RSEL] ? ib_r : ic_r;
      s_bus_out                   <= ex_r[MW_SSEL] ? cur_r : sw_r;
      rd_data_out                 <= rd_nxt;
    end

  assign prefetch_current_out = cur_r;
  assign prefetch_next_out    = pnx_r;
  assign input_buffer_out     = ib_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [3:0] cnt_r;
  logic       wt_r;
  always_ff @(posedge clk_in or negedge rstn_in)
    if (!rstn_in)
    begin
      cnt_r <= 4'h0;
      wt_r  <= 1'b0;
    end
    else if (stall_r || end_c)
    begin
      cnt_r <= 4'h0;
      wt_r  <= 1'b0;
    end
    else if (osc_fall)
    begin
      cnt_r <= cnt_r + 4'h1;
      wt_r  <= wt_r || (ph_r == PWAIT);
    end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_wait;
    ph_r == PWAIT;
  endsequence
  sequence s_held;
    cycle_sync_n_out && precharge_clock_n_out && !phase_two_clock_n_out
      && !data_strobe_n_out && !addr_strobe_out;
  endsequence

  property p_flag_zero;
    end_c && ex_r[MW_FLG] |=> sw_r[F_ZERO] == ($past(y_bus_in) == 16'h0000);
  endproperty
  a_flag_zero: assert property (p_flag_zero) else $error("zero flag wrong");
  property p_flag_hold;
    !(end_c && ex_r[MW_FLG]) && !(wr_in && addr_in == ADR_STATUS) |=> $stable(sw_r[3:0]);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flags changed");
  property p_ic_inc;
    end_c && ex_r[MW_INC] && !ex_r[MW_ICL] && !wr_in |=> ic_r == $past(ic_r) + 16'h0001;
  endproperty
  a_ic_inc: assert property (p_ic_inc) else $error("counter did not step");
  property p_advance;
    end_c && ex_r[MW_ADV] |=> cur_r == $past(pnx_r);
  endproperty
  a_advance: assert property (p_advance) else $error("prefetch not moved");
  property p_wait_held;
    s_wait ##1 s_wait |=> s_held;
  endproperty
  a_wait_held: assert property (p_wait_held) else $error("stretch levels wrong");
  property p_wait_end;
    s_wait and osc_fall && bop != BOP_IIO && !rdy_n |=> ph_r == PH0;
  endproperty
  a_wait_end: assert property (p_wait_end) else $error("wait did not end");
  property p_len;
    end_c && !wt_r && ph_r != PWAIT |-> cnt_r + 4'h1 == (long_c ? 4'(LONG_OSC) : 4'(BASE_OSC));
  endproperty
  a_len: assert property (p_len) else $error("cycle length wrong");
  property p_iio_min;
    end_c && bop == BOP_IIO |-> cnt_r + 4'h1 >= 4'(LONG_OSC);
  endproperty
  a_iio_min: assert property (p_iio_min) else $error("internal io too short");
  property p_pause_low;
    !pause_n |=> !internal_cycle_clock_n_out && !precharge_clock_n_out;
  endproperty
  a_pause_low: assert property (p_pause_low) else $error("clock not held low");
  property p_sync_start;
    end_c |=> ph_r == PH0 ##1 !cycle_sync_n_out;
  endproperty
  a_sync_start: assert property (p_sync_start) else $error("no sync fall");
endmodule // ecs_exec_cycle
`default_nettype wire

// *** design/ecs_pkg.sv ***
// Purpose: shared constants and types of the execution cycle and state logic
// Assumes: registers sit on a plain strobe port, byte addresses, 32-bit data
// Notes:   microword layout and register offsets are local to this block
package ecs_pkg;
  // register map
  localparam logic [7:0] ADR_STATUS = 8'h00;
  localparam logic [7:0] ADR_ICNT   = 8'h04;
  localparam logic [7:0] ADR_PCUR   = 8'h08;
  localparam logic [7:0] ADR_PNXT   = 8'h0C;
  localparam logic [7:0] ADR_INBUF  = 8'h10;
  localparam logic [7:0] ADR_SEQ    = 8'h14;
  // status word fields
  localparam int F_CARRY = 0;
  localparam int F_POS   = 1;
  localparam int F_ZERO  = 2;
  localparam int F_NEG   = 3;
  localparam int PS_LO   = 8;
  localparam int AS_LO   = 12;
  localparam logic [15:0] SW_MASK = 16'hFF0F;
  localparam logic [15:0] SW_RST  = 16'h0000;
  localparam logic [15:0] IC_RST  = 16'h0000;
  // microword fields
  localparam int MW_BOP  = 0;
  localparam int MW_IOP  = 2;
  localparam int MW_MEM  = 3;
  localparam int MW_BRA  = 4;
  localparam int MW_FLG  = 5;
  localparam int MW_ICL  = 6;
  localparam int MW_INC  = 7;
  localparam int MW_ADV  = 8;
  localparam int MW_IMM  = 9;
  localparam int MW_SWL  = 10;
  localparam int MW_ADL  = 11;
  localparam int MW_DOL  = 12;
  localparam int MW_CND  = 13;
  localparam int MW_RSEL = 17;
  localparam int MW_SSEL = 18;
  // oscillator cycles per machine cycle
  localparam int BASE_OSC = 5;
  localparam int LONG_OSC = 6;
  typedef enum logic [1:0] {
    BOP_NONE  = 2'h0,
    BOP_READ  = 2'h1,
    BOP_WRITE = 2'h2,
    BOP_IIO   = 2'h3
  } ecs_bop_t;
  typedef enum logic [2:0] {
    PH0   = 3'h0,
    PH1   = 3'h1,
    PH2   = 3'h3,
    PH3   = 3'h2,
    PH4   = 3'h6,
    PH5   = 3'h7,
    PWAIT = 3'h5
  } ecs_phase_t;
endpackage

// *** tb/ecs_far_model.sv ***
// Purpose: far side of the cycle link: memory or I/O and the interrupt unit ready
// Assumes: ready is judged on the link clock, never on clk_in
// Notes:   wait counts come from the bench and may change between cycles
`timescale 1ns/10ps
`default_nettype none
module ecs_far_model (
  input  wire logic        timebase_in,
  input  wire logic        cycle_sync_n_in,
  input  wire logic        data_strobe_n_in,
  input  wire logic        read_write_n_in,
  input  wire logic        ad_oe_in,
  input  wire logic [15:0] ad_drv_in,
  input  wire logic [15:0] mem_data_in,
  input  wire logic [3:0]  bus_waits_in,
  input  wire logic [3:0]  iu_waits_in,
  output logic             bus_ready_n_out,
  output logic             intr_unit_ready_n_out,
  output logic      [15:0] ad_out
);
  logic [3:0]  osc_cnt_r = 4'h0;
  logic [15:0] last_r    = 16'h0000;
  logic        mem_drv;
  initial bus_ready_n_out = 1'b1;
  initial intr_unit_ready_n_out = 1'b1;
  ////////////////////////////////////////////////////////////////////////////////
  // oscillator periods since sync went high
  always @(negedge timebase_in) osc_cnt_r <= cycle_sync_n_in ? osc_cnt_r + 4'h1 : 4'h0;
  always @(posedge timebase_in)
  begin
    bus_ready_n_out       <= !(!data_strobe_n_in && osc_cnt_r >= 4'h2 + bus_waits_in);
    intr_unit_ready_n_out <= !(!data_strobe_n_in && osc_cnt_r >= 4'h2 + iu_waits_in);
  end
  ////////////////////////////////////////////////////////////////////////////////
  assign mem_drv = !data_strobe_n_in && read_write_n_in && !ad_oe_in;
  always @(posedge timebase_in) if (ad_oe_in || mem_drv) last_r <= ad_out;
  // a released bus shows the inverse of its last value, so late capture shows up
  assign ad_out = ad_oe_in ? ad_drv_in : (mem_drv ? mem_data_in : ~last_r);
endmodule // ecs_far_model
`default_nettype wire

// *** tb/ecs_exec_cycle_test.sv ***
// Purpose: self-checking bench of the cycle clocks, status word and fetch registers
// Assumes: microwords change only right after a cycle boundary
// Notes:   cycle lengths are counted in clk_in periods, 8 per oscillator period
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module ecs_exec_cycle_test;
  import ecs_pkg::*;
  logic        clk_in = 1'b0, rstn_in = 1'b0, timebase_in = 1'b1;
  logic        wr_in = 1'b0, rd_in = 1'b0, y_carry_in = 1'b0;
  logic        dma_pause_n_in = 1'b1, hold_req_n_in = 1'b1;
  logic [7:0]  addr_in = 8'h00;
  logic [31:0] wr_data_in = 32'h0, rd_data_out, d, p;
  logic [19:0] microcode_in = 20'h0, w29;
  logic [15:0] y_bus_in = 16'h0, mem_data = 16'h0, ad_out, r_bus_out, s_bus_out;
  logic [15:0] prefetch_current_out, prefetch_next_out, input_buffer_out;
  logic [3:0]  bus_waits = 4'h0, iu_waits = 4'h0;
  wire logic [15:0] ad_bus;
  wire logic   bus_ready_n_in, intr_unit_ready_n_in;
  logic        ad_oe_out, cycle_sync_n_out, intr_unit_cycle_clock_n_out;
  logic        internal_cycle_clock_n_out, precharge_clock_n_out, phase_two_clock_n_out;
  logic        addr_strobe_out, data_strobe_n_out, read_write_n_out, instr_or_operand_out;
  logic        memory_or_io_out, ctrl_oe_out, hold_ack_n_out, branch_taken_out;
  logic [4:0]  s5, s13, s29, s53;
  logic [17:0] a5;
  logic [33:0] t29;
  int          miscompares = 0, comparisons = 0, cyc = 0;
  logic [15:0] fy [3] = '{16'h0000, 16'h8000, 16'h0001};
  logic        fc [3] = '{1'b1, 1'b0, 1'b1};
  logic [3:0]  ff [3] = '{4'h5, 4'h8, 4'h3};

  ecs_exec_cycle ecs_exec_cycle_i (
    .clk_in, .rstn_in, .addr_in, .wr_data_in, .wr_in, .rd_in, .rd_data_out, .timebase_in,
    .bus_ready_n_in, .intr_unit_ready_n_in, .dma_pause_n_in, .hold_req_n_in, .microcode_in,
    .y_bus_in, .y_carry_in, .ad_in(ad_bus), .ad_out, .ad_oe_out, .cycle_sync_n_out,
    .intr_unit_cycle_clock_n_out, .internal_cycle_clock_n_out, .precharge_clock_n_out,
    .phase_two_clock_n_out, .addr_strobe_out, .data_strobe_n_out, .read_write_n_out,
    .instr_or_operand_out, .memory_or_io_out, .ctrl_oe_out, .hold_ack_n_out,
    .branch_taken_out, .r_bus_out, .s_bus_out, .prefetch_current_out, .prefetch_next_out,
    .input_buffer_out);
  ecs_far_model ecs_far_model_i (
    .timebase_in, .cycle_sync_n_in(cycle_sync_n_out), .data_strobe_n_in(data_strobe_n_out),
    .read_write_n_in(read_write_n_out), .ad_oe_in(ad_oe_out), .ad_drv_in(ad_out),
    .mem_data_in(mem_data), .bus_waits_in(bus_waits), .iu_waits_in(iu_waits),
    .bus_ready_n_out(bus_ready_n_in), .intr_unit_ready_n_out(intr_unit_ready_n_in),
    .ad_out(ad_bus));
  ////////////////////////////////////////////////////////////////////////////////
  always #10 clk_in = ~clk_in;
  // oscillator edges sit 10 ns off every clk_in rising edge
  always #80 timebase_in = ~timebase_in;
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      miscompares++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [19:0] mwb(input int i);
    return 20'h00001 << i;
  endfunction
  function automatic logic [4:0] ck();
    return {cycle_sync_n_out, intr_unit_cycle_clock_n_out, internal_cycle_clock_n_out,
            precharge_clock_n_out, phase_two_clock_n_out};
  endfunction
  task automatic tick;
    @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wr_data_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    v = rd_data_out;
  endtask
  task automatic sety(input logic [15:0] v, input logic c);
    @(posedge clk_in);
    y_bus_in <= v;
    y_carry_in <= c;
  endtask
  task automatic sync_fall;
    int k;
    k = 0;
    while (cycle_sync_n_out !== 1'b1 && k < 400) begin tick(); k++; end
    while (cycle_sync_n_out !== 1'b0 && k < 800) begin tick(); k++; end
    if (k >= 800) miscompares++;
  endtask
  // one microword is loaded at one boundary; the next cycle is measured
  task automatic mcycle(input logic [19:0] mw, input int osc);
    int n;
    sync_fall();
    @(posedge clk_in);
    microcode_in <= mw;
    sync_fall();
    @(posedge clk_in);
    microcode_in <= 20'h00000;
    n = 1;
    do
    begin
      tick();
      n++;
      if (n == 5) s5 = ck();
      if (n == 5) a5 = {addr_strobe_out, ad_oe_out, ad_out};
      if (n == 13) s13 = ck();
      if (n == 29) s29 = ck();
      if (n == 29) w29 = {data_strobe_n_out, read_write_n_out, memory_or_io_out, ad_oe_out, ad_out};
      if (n == 29) t29 = {branch_taken_out, instr_or_operand_out, r_bus_out, s_bus_out};
      if (n == 53) s53 = {cycle_sync_n_out, precharge_clock_n_out, phase_two_clock_n_out,
                          addr_strobe_out, data_strobe_n_out};
    end
    while ((n < 20 || cycle_sync_n_out !== 1'b0) && n < 400);
    `CHK(n, 8 * osc)
  endtask
  task automatic end_sim;
    $display("counts: %0d compares, %0d mismatches", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int k;
    repeat (4) @(posedge clk_in);
    rstn_in <= 1'b1;
    rd(ADR_STATUS, d);
    `CHK(d, 32'(SW_RST))
    rd(ADR_ICNT, d);
    `CHK(d, 32'(IC_RST))
    rd(8'h20, d);
    `CHK(d, 32'h0)
    wr(ADR_STATUS, 32'hFFFF_FFFF);
    rd(ADR_STATUS, d);
    `CHK(d, 32'(SW_MASK))
    tick();
    `CHK(rd_data_out, 32'h0)
    rd(ADR_PCUR, p);
    wr(ADR_PCUR, 32'h0000_FFFF);
    rd(ADR_PCUR, d);
    `CHK(d, p)
    $display("test registers done");
    for (int i = 0; i < 3; i++)
    begin
      sety(fy[i], fc[i]);
      mcycle(mwb(MW_FLG), 5);
      rd(ADR_STATUS, d);
      `CHK(d, {16'h0000, 8'hFF, 4'h0, ff[i]})
    end
    sety(16'h0000, 1'b0);
    mcycle(20'h00000, 5);
    rd(ADR_STATUS, d);
    `CHK(d, 32'h0000_FF03)
    sety(16'hA5F3, 1'b0);
    mcycle(mwb(MW_SWL), 5);
    rd(ADR_STATUS, d);
    `CHK(d, 32'h0000_A503)
    $display("test status done");
    wr(ADR_ICNT, 32'h0000_0010);
    mcycle(mwb(MW_INC), 5);
    rd(ADR_ICNT, d);
    `CHK(d, 32'h0000_0011)
    `CHK(r_bus_out, 16'h0011)
    `CHK(s_bus_out, 16'hA503)
    wr(ADR_STATUS, 32'h0000_0004);
    sety(16'h0100, 1'b0);
    mcycle(mwb(MW_ICL) | (20'h00004 << MW_CND), 5);
    `CHK(t29[33], 1'b1)
    rd(ADR_ICNT, d);
    `CHK(d, 32'h0000_0100)
    sety(16'h0200, 1'b0);
    mcycle(mwb(MW_ICL) | (20'h00008 << MW_CND), 5);
    `CHK(t29[33], 1'b0)
    rd(ADR_ICNT, d);
    `CHK(d, 32'h0000_0100)
    mcycle(mwb(MW_ICL), 5);
    rd(ADR_ICNT, d);
    `CHK(d, 32'h0000_0200)
    mcycle(mwb(MW_BRA), 6);
    $display("test counter done");
    sety(16'h0040, 1'b0);
    mcycle(mwb(MW_ADL), 5);
    sety(16'hBEEF, 1'b0);
    mcycle(mwb(MW_DOL), 5);
    mcycle(20'(BOP_WRITE) | mwb(MW_MEM), 5);
    `CHK(a5, 18'h30040)
    `CHK(w29, 20'h3BEEF)
    `CHK(t29[32], 1'b0)
    `CHK(s5, 5'b00001)
    `CHK(s13, 5'b00011)
    `CHK(s29, 5'b11110)
    bus_waits <= 4'h3;
    mem_data <= 16'h5A5A;
    mcycle(20'(BOP_READ) | mwb(MW_MEM) | mwb(MW_IOP) | mwb(MW_ADV), 8);
    `CHK(s53, 5'b11000)
    `CHK(w29[19:16], 4'b0110)
    `CHK(t29[32], 1'b1)
    rd(ADR_PNXT, d);
    `CHK(d, 32'h0000_5A5A)
    rd(ADR_INBUF, d);
    `CHK(d, 32'h0000_5A5A)
    bus_waits <= 4'h0;
    mem_data <= 16'h6B6B;
    mcycle(20'(BOP_READ) | mwb(MW_MEM) | mwb(MW_IOP) | mwb(MW_ADV), 5);
    `CHK(prefetch_current_out, 16'h5A5A)
    `CHK(prefetch_next_out, 16'h6B6B)
    mem_data <= 16'h7C7C;
    mcycle(20'(BOP_READ) | mwb(MW_MEM) | mwb(MW_IOP) | mwb(MW_ADV) | mwb(MW_IMM), 5);
    `CHK(prefetch_current_out, 16'h6B6B)
    `CHK(prefetch_next_out, 16'h7C7C)
    `CHK(input_buffer_out, 16'h6B6B)
    mem_data <= 16'h1234;
    mcycle(20'(BOP_READ) | mwb(MW_RSEL) | mwb(MW_SSEL), 5);
    `CHK(w29[19:16], 4'b0100)
    `CHK(t29[31:0], 32'h6B6B_6B6B)
    `CHK({prefetch_next_out, input_buffer_out}, 32'h7C7C_1234)
    $display("test bus done");
    mcycle(20'(BOP_IIO), 6);
    iu_waits <= 4'h3;
    mcycle(20'(BOP_IIO), 8);
    `CHK(s53, 5'b11000)
    $display("test internal io done");
    @(posedge clk_in);
    dma_pause_n_in <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      repeat (60) tick();
      `CHK({internal_cycle_clock_n_out, precharge_clock_n_out, phase_two_clock_n_out, ctrl_oe_out}, 4'b0010)
    end
    @(posedge clk_in);
    dma_pause_n_in <= 1'b1;
    mcycle(20'h00000, 5);
    @(posedge clk_in);
    hold_req_n_in <= 1'b0;
    k = 0;
    while (hold_ack_n_out !== 1'b0 && k < 400) begin tick(); k++; end
    `CHK({hold_ack_n_out, internal_cycle_clock_n_out, ctrl_oe_out}, 3'b000)
    rd(ADR_SEQ, d);
    `CHK(d, 32'h0000_0018)
    @(posedge clk_in);
    hold_req_n_in <= 1'b1;
    k = 0;
    while (hold_ack_n_out !== 1'b1 && k < 400) begin tick(); k++; end
    `CHK(hold_ack_n_out, 1'b1)
    mcycle(20'h00000, 5);
    $display("test pause and hold done");
    end_sim();
  end
endmodule // ecs_exec_cycle_test
`default_nettype wire
